/* File: hw/pwd_pkg.sv */
// Package: register map, fields, reset values and timing for the port watchdog block
package pwd_pkg;
    localparam logic [7:0] ADDR_GLOBAL_PUSHBUTTONS = 8'h1A;
    localparam logic [7:0] ADDR_IDENTIFICATION     = 8'h1B;
    localparam logic [7:0] ADDR_HW_FLAG_TWO_EVENT  = 8'h1C;
    localparam logic [7:0] ADDR_WATCHDOG_COUNT     = 8'h1E;
    localparam logic [7:0] ADDR_SWITCH_MODE        = 8'h1F;
    localparam logic [7:0] ADDR_DETECTION_PROGRAM  = 8'h23;
    localparam logic [7:0] ADDR_HIGH_POWER_SETTING = 8'h24;
    localparam logic [7:0] ADDR_MISC_CONFIG_TWO    = 8'h29;

    localparam int BIT_INT_CLEAR      = 7;
    localparam int BIT_CHIP_RESET     = 4;
    localparam int BIT_WATCHDOG_EN    = 7;
    localparam int BIT_HW_FLAG_IRQ_EN = 6;
    localparam int BIT_LARGE_CAP      = 5;
    localparam int BIT_DETECT_BYPASS  = 4;
    localparam int BIT_OSC_IGNORE     = 3;

    localparam logic [7:0] RST_HW_FLAG_TWO_EVENT  = 8'h00;
    localparam logic [7:0] RST_WATCHDOG_COUNT     = 8'h00;
    localparam logic [7:0] RST_SWITCH_MODE        = 8'h00;
    localparam logic [7:0] RST_DETECTION_PROGRAM  = 8'h04;
    localparam logic [7:0] RST_HIGH_POWER_SETTING = 8'h00;
    localparam logic [7:0] RST_MISC_CONFIG_TWO    = 8'h00;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] MASK_SWITCH_MODE        = 8'hCF;
    localparam logic [7:0] MASK_DETECTION_PROGRAM  = 8'h3F;
    localparam logic [7:0] MASK_HIGH_POWER_SETTING = 8'h70;
    localparam logic [7:0] MASK_MISC_CONFIG_TWO    = 8'h03;

    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_MANUAL   = 2'h1;
    localparam logic [1:0] MODE_AUTO     = 2'h3;

    localparam int CLOCK_HZ             = 100_000_000;
    localparam int WD_TICK_MS           = 164;
    localparam int WD_TICK_CYCLES       = CLOCK_HZ / 1000 * WD_TICK_MS;
    localparam int CLASS_GAP_US         = 21300;
    localparam int CLASS_GAP_CYCLES     = CLOCK_HZ / 1_000_000 * CLASS_GAP_US;
    localparam int CLASS_REPEATS        = 3;

    typedef enum logic [1:0] {
        PWD_CL_IDLE = 2'b00,
        PWD_CL_RUN  = 2'b01,
        PWD_CL_HOLD = 2'b10
    } pwd_class_state_t;
endpackage

/* File: hw/pwd_watchdog_regs.sv */
// Watchdog, pushbutton strobes and configuration registers of a four-port power controller
//
// Summary of operation
// R1 - Writing one to bit 7 of pushbuttons clears all pending interrupts.
// R2 - Writing one to bit 4 of pushbuttons resets the whole device.
// R3 - Pushbutton bits 0 to 3 reset ports 1 to 4 individually.
// R4 - Port reset removes power, clears that port's status; strobes self-clear.
// R5 - Interrupt clear clears events and interrupt bits; soft reset restores map.
// R6 - Identification register is read-only: part code 7:3, revision 2:0.
// R7 - Two-event enable runs classification three times, 21.3ms apart.
// R8 - Between repeated classifications the port is held near -9V.
// R9 - Two-event enable honoured only in auto or semi-automatic mode.
// R10 - Hardware-control flag sets when watchdog reaches zero.
// R11 - Flag also sets on each refused power-on under hardware control.
// R12 - Hardware-control flags clear when their register is read.
// R13 - Watchdog enable bit 7 starts count; decrements every 164ms.
// R14 - Software must rewrite a nonzero count before zero to avoid expiry.
// R15 - On expiry each port goes to auto (11) or shutdown (00).
// R16 - Under hardware control, power-on requests are ignored.
// R17 - Under hardware control, software cannot change port mode.
// R18 - With bit 6 of switch mode set, any flag raises an interrupt.
// R19 - Large-capacitor enable lets detection accept loads up to 150uF.
// R20 - AC threshold field N sets comparator to 226.68uA plus 28.33N.
// R21 - Bypass clear refuses undetected auto power-on; set allows it.
// R22 - Oscillator-fail ignore bit masks the oscillator-failure flag.
// R23 - Class 4, 5 or 6 discovery loads high-power default into current limit.
// R24 - Scaling field lowers current limit to hold power at higher supply.
// R25 - Scaling codes: 00 default, 01 -5%, 10 -10%, 11 -15%.
// R26 - Watchdog count stops at zero, expires once, resumes on nonzero write.
`timescale 1ns/100ps
module pwd_watchdog_regs #(
    parameter int          NUM_PORTS        = 4,
    parameter logic [4:0]  PART_CODE        = 5'h0A,  // Arbitrary value
    parameter logic [2:0]  REVISION_CODE    = 3'h1,   // Arbitrary value
    parameter int          WD_TICK_CYCLES   = pwd_pkg::WD_TICK_CYCLES,
    parameter int          CLASS_GAP_CYCLES = pwd_pkg::CLASS_GAP_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    input  wire logic [NUM_PORTS*2-1:0] sw_mode_write_data,
    input  wire logic [NUM_PORTS-1:0]   sw_mode_write,
    input  wire logic [NUM_PORTS-1:0]   sw_power_on_req,
    input  wire logic [NUM_PORTS-1:0]   class_request,
    input  wire logic [NUM_PORTS-1:0]   class_done,
    input  wire logic [NUM_PORTS-1:0]   class_high_found,
    input  wire logic                   oscillator_failure_flag,
    input  wire logic [NUM_PORTS-1:0]   detection_skipped,
    output logic      [NUM_PORTS*2-1:0] port_mode,
    output logic      [NUM_PORTS-1:0]   power_on_grant,
    output logic      [NUM_PORTS-1:0]   port_soft_reset,
    output logic                        interrupt_clear_strobe,
    output logic                        hw_flag_irq,
    output logic                        hw_controlled,
    output logic      [NUM_PORTS-1:0]   class_cycle_start,
    output logic      [NUM_PORTS-1:0]   class_hold_mid_level,
    output logic                        large_cap_detect_enable,
    output logic      [2:0]             ac_disconnect_threshold,
    output logic                        detect_bypass_allow,
    output logic                        oscillator_failure_flag_effective,
    output logic      [NUM_PORTS*3-1:0] current_limit_select,
    output logic      [NUM_PORTS-1:0]   current_limit_load,
    output logic      [1:0]             current_limit_scale,
    output logic      [6:0]             current_limit_percent
);
    logic [NUM_PORTS-1:0] two_event_class_enable;
    logic [NUM_PORTS-1:0] hw_control_flag;
    logic [7:0]           watchdog_count;
    logic [7:0]           switch_mode;
    logic [7:0]           detection_program;
    logic [7:0]           high_power_setting;
    logic [7:0]           misc_config_two;
    logic                 chip_soft_reset;
    logic [31:0]          wd_tick_cnt;
    logic                 wd_tick;
    logic                 wd_expire;
    logic                 wr_pb;
    logic                 rd_flags;

    assign wr_pb    = reg_write && reg_addr == pwd_pkg::ADDR_GLOBAL_PUSHBUTTONS;
    assign rd_flags = reg_read && reg_addr == pwd_pkg::ADDR_HW_FLAG_TWO_EVENT;
    assign hw_controlled = |hw_control_flag || wd_expire;

    // Strobes are one-cycle pulses, so they return to zero without software
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_clear_strobe <= 1'b0;
            chip_soft_reset        <= 1'b0;
            port_soft_reset        <= '0;
        end else begin
            interrupt_clear_strobe <= wr_pb && reg_wdata[pwd_pkg::BIT_INT_CLEAR]; // R1 R5 R4
            chip_soft_reset        <= wr_pb && reg_wdata[pwd_pkg::BIT_CHIP_RESET]; // R2 R4
            port_soft_reset        <= wr_pb ? reg_wdata[NUM_PORTS-1:0] : '0; // R3 R4
        end
    end

    // Configuration registers; soft reset restores the whole map
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            two_event_class_enable <= pwd_pkg::RST_HW_FLAG_TWO_EVENT[7:4];
            switch_mode            <= pwd_pkg::RST_SWITCH_MODE;
            detection_program      <= pwd_pkg::RST_DETECTION_PROGRAM;
            high_power_setting     <= pwd_pkg::RST_HIGH_POWER_SETTING;
            misc_config_two        <= pwd_pkg::RST_MISC_CONFIG_TWO;
        end else if (chip_soft_reset) begin // R5
            two_event_class_enable <= pwd_pkg::RST_HW_FLAG_TWO_EVENT[7:4];
            switch_mode            <= pwd_pkg::RST_SWITCH_MODE;
            detection_program      <= pwd_pkg::RST_DETECTION_PROGRAM;
            high_power_setting     <= pwd_pkg::RST_HIGH_POWER_SETTING;
            misc_config_two        <= pwd_pkg::RST_MISC_CONFIG_TWO;
        end else if (reg_write) begin
            unique case (reg_addr)
                pwd_pkg::ADDR_HW_FLAG_TWO_EVENT:  two_event_class_enable <= reg_wdata[7:4];
                pwd_pkg::ADDR_SWITCH_MODE:        switch_mode <= reg_wdata & pwd_pkg::MASK_SWITCH_MODE;
                pwd_pkg::ADDR_DETECTION_PROGRAM:
                    detection_program <= reg_wdata & pwd_pkg::MASK_DETECTION_PROGRAM;
                pwd_pkg::ADDR_HIGH_POWER_SETTING:
                    high_power_setting <= reg_wdata & pwd_pkg::MASK_HIGH_POWER_SETTING;
                pwd_pkg::ADDR_MISC_CONFIG_TWO:
                    misc_config_two <= reg_wdata & pwd_pkg::MASK_MISC_CONFIG_TWO;
                default: ;
            endcase
        end
    end

    // Watchdog tick prescaler, free running only while enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_tick_cnt <= '0;
        end else if (chip_soft_reset || !switch_mode[pwd_pkg::BIT_WATCHDOG_EN]) begin
            wd_tick_cnt <= '0;
        end else if (wd_tick) begin
            wd_tick_cnt <= '0;
        end else begin
            wd_tick_cnt <= wd_tick_cnt + 32'd1;
        end
    end
    assign wd_tick = wd_tick_cnt == 32'(WD_TICK_CYCLES - 1); // R13

    // Count holds at zero; a software write of nonzero restarts it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_count <= pwd_pkg::RST_WATCHDOG_COUNT;
            wd_expire      <= 1'b0;
        end else if (chip_soft_reset) begin
            watchdog_count <= pwd_pkg::RST_WATCHDOG_COUNT;
            wd_expire      <= 1'b0;
        end else begin
            wd_expire <= 1'b0;
            if (reg_write && reg_addr == pwd_pkg::ADDR_WATCHDOG_COUNT) begin
                watchdog_count <= reg_wdata; // R14
            end else if (wd_tick && watchdog_count != 8'h00) begin
                watchdog_count <= watchdog_count - 8'h01; // R13
                wd_expire      <= watchdog_count == 8'h01; // R26
            end
        end
    end

    // Flags: hardware set wins over clear-on-read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hw_control_flag <= '0;
        end else if (chip_soft_reset) begin
            hw_control_flag <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (wd_expire || (|hw_control_flag && sw_power_on_req[p])) begin
                    hw_control_flag[p] <= 1'b1; // R10 R11
                end else if (rd_flags) begin
                    hw_control_flag[p] <= 1'b0; // R12
                end
            end
        end
    end
    assign hw_flag_irq = switch_mode[pwd_pkg::BIT_HW_FLAG_IRQ_EN] && |hw_control_flag; // R18

    // Port mode: expiry forces mode; software locked out under hardware control
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_mode <= '0;
        end else if (chip_soft_reset) begin
            port_mode <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (wd_expire) begin
                    port_mode[p*2 +: 2] <= switch_mode[p] ? pwd_pkg::MODE_AUTO : pwd_pkg::MODE_SHUTDOWN; // R15
                end else if (sw_mode_write[p] && !hw_controlled) begin
                    port_mode[p*2 +: 2] <= sw_mode_write_data[p*2 +: 2]; // R17
                end
            end
        end
    end

    // Power-on grant; a reset port, or missing detection in auto mode with bypass clear, refuses it
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            power_on_grant[p] = sw_power_on_req[p] && !hw_controlled && !port_soft_reset[p] // R16 R4
                && !(detection_skipped[p] && port_mode[p*2 +: 2] == pwd_pkg::MODE_AUTO
                     && !detection_program[pwd_pkg::BIT_DETECT_BYPASS]); // R21
        end
    end

    // Two-event classification sequencer, one per port
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_class
        pwd_pkg::pwd_class_state_t state;
        logic [31:0]               gap_cnt;
        logic [1:0]                runs;
        logic                      mode_ok;
        assign mode_ok = port_mode[g*2 +: 2] != pwd_pkg::MODE_MANUAL
                      && port_mode[g*2 +: 2] != pwd_pkg::MODE_SHUTDOWN; // R9
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                state             <= pwd_pkg::PWD_CL_IDLE;
                gap_cnt           <= '0;
                runs              <= '0;
                class_cycle_start[g] <= 1'b0;
            end else if (chip_soft_reset || port_soft_reset[g]) begin
                state             <= pwd_pkg::PWD_CL_IDLE;
                gap_cnt           <= '0;
                runs              <= '0;
                class_cycle_start[g] <= 1'b0;
            end else begin
                class_cycle_start[g] <= 1'b0;
                unique case (state)
                    pwd_pkg::PWD_CL_IDLE: begin
                        if (class_request[g]) begin
                            class_cycle_start[g] <= 1'b1;
                            runs  <= 2'd1;
                            state <= pwd_pkg::PWD_CL_RUN;
                        end
                    end
                    pwd_pkg::PWD_CL_RUN: begin
                        if (class_done[g]) begin
                            if (two_event_class_enable[g] && mode_ok
                                && runs < 2'(pwd_pkg::CLASS_REPEATS)) begin // R7 R9
                                gap_cnt <= '0;
                                state   <= pwd_pkg::PWD_CL_HOLD;
                            end else begin
                                state <= pwd_pkg::PWD_CL_IDLE;
                            end
                        end
                    end
                    pwd_pkg::PWD_CL_HOLD: begin
                        if (gap_cnt == 32'(CLASS_GAP_CYCLES - 1)) begin
                            class_cycle_start[g] <= 1'b1; // R7
                            runs  <= runs + 2'd1;
                            state <= pwd_pkg::PWD_CL_RUN;
                        end else begin
                            gap_cnt <= gap_cnt + 32'd1;
                        end
                    end
                    default: state <= pwd_pkg::PWD_CL_IDLE;
                endcase
            end
        end
        assign class_hold_mid_level[g] = state == pwd_pkg::PWD_CL_HOLD; // R8

        // High-power default loaded into the current-limit selection
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                current_limit_select[g*3 +: 3] <= 3'h0;
                current_limit_load[g]          <= 1'b0;
            end else if (chip_soft_reset || port_soft_reset[g]) begin
                current_limit_select[g*3 +: 3] <= 3'h0;
                current_limit_load[g]          <= 1'b0;
            end else begin
                current_limit_load[g] <= class_high_found[g];
                if (class_high_found[g]) begin
                    current_limit_select[g*3 +: 3] <= high_power_setting[6:4]; // R23
                end
            end
        end
    end

    assign large_cap_detect_enable = detection_program[pwd_pkg::BIT_LARGE_CAP]; // R19
    // Analog side forms 226.68uA + 28.33uA x N from this code
    assign ac_disconnect_threshold = detection_program[2:0]; // R20
    assign detect_bypass_allow     = detection_program[pwd_pkg::BIT_DETECT_BYPASS]; // R21
    assign oscillator_failure_flag_effective      = oscillator_failure_flag
                                   && !detection_program[pwd_pkg::BIT_OSC_IGNORE]; // R22
    assign current_limit_scale     = misc_config_two[1:0]; // R24

    // Percentage of the default current limit left after scaling
    always_comb begin
        unique case (misc_config_two[1:0])
            2'h0: current_limit_percent = 7'd100; // R25
            2'h1: current_limit_percent = 7'd95;
            2'h2: current_limit_percent = 7'd90;
            2'h3: current_limit_percent = 7'd85;
        endcase
    end

    // Read mux; pushbuttons are write-only and read zero
    always_comb begin
        unique case (reg_addr)
            pwd_pkg::ADDR_IDENTIFICATION:     reg_rdata = {PART_CODE, REVISION_CODE}; // R6
            pwd_pkg::ADDR_HW_FLAG_TWO_EVENT:  reg_rdata = {two_event_class_enable, hw_control_flag};
            pwd_pkg::ADDR_WATCHDOG_COUNT:     reg_rdata = watchdog_count;
            pwd_pkg::ADDR_SWITCH_MODE:        reg_rdata = switch_mode;
            pwd_pkg::ADDR_DETECTION_PROGRAM:  reg_rdata = detection_program;
            pwd_pkg::ADDR_HIGH_POWER_SETTING: reg_rdata = high_power_setting;
            pwd_pkg::ADDR_MISC_CONFIG_TWO:    reg_rdata = misc_config_two;
            default:                          reg_rdata = 8'h00;
        endcase
    end
endmodule

/* File: tb/pwd_checker_sva.sv */
// Checker: port-level properties of the watchdog and configuration block
`timescale 1ns/100ps
module pwd_checker #(
    parameter logic [4:0] PART_CODE     = 5'h0A,  // Arbitrary value
    parameter logic [2:0] REVISION_CODE = 3'h1    // Arbitrary value
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] sw_mode_write,
    input wire logic [7:0] port_mode,
    input wire logic [3:0] power_on_grant,
    input wire logic [3:0] port_soft_reset,
    input wire logic       interrupt_clear_strobe,
    input wire logic       hw_flag_irq,
    input wire logic       hw_controlled,
    input wire logic       oscillator_failure_flag,
    input wire logic       oscillator_failure_flag_effective,
    input wire logic [1:0] current_limit_scale,
    input wire logic [6:0] current_limit_percent
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_pb_wr;
        reg_write && reg_addr == 8'h1A;
    endsequence
    // Two cycles in hardware control, so a forced mode change has already landed
    sequence s_locked;
        hw_controlled ##1 hw_controlled && sw_mode_write != 4'h0;
    endsequence
    AST_PB_PORT: assert property (s_pb_wr |=> {4'h0, port_soft_reset} == ($past(reg_wdata) & 8'h0F))
        else $error("port reset strobes differ from written bits");
    AST_PB_SELF_CLEAR: assert property (!(reg_write && reg_addr == 8'h1A) |=> port_soft_reset == 4'h0 && !interrupt_clear_strobe)
        else $error("pushbutton strobe without a write");
    AST_INT_CLEAR: assert property (s_pb_wr ##0 reg_wdata[7] |=> interrupt_clear_strobe)
        else $error("interrupt clear strobe missing");
    AST_ID_READ: assert property (reg_addr == 8'h1B |-> reg_rdata == {PART_CODE, REVISION_CODE})
        else $error("identification read wrong");
    AST_NO_GRANT: assert property (hw_controlled |-> power_on_grant == 4'h0)
        else $error("power-on granted under hardware control");
    AST_MODE_LOCK: assert property (s_locked |=> $stable(port_mode))
        else $error("port mode changed under hardware control");
    AST_IRQ_CAUSE: assert property (hw_flag_irq |-> hw_controlled)
        else $error("flag interrupt without a flag");
    AST_OSC_MASK: assert property (oscillator_failure_flag_effective |-> oscillator_failure_flag)
        else $error("oscillator failure shown without cause");
    AST_SCALE: assert property (current_limit_percent == 7'h64 - 7'h05 * {5'h00, current_limit_scale})
        else $error("current limit percent wrong");
endmodule

/* File: tb/pwd_host_model.sv */
// Host model: register writes and reads over the block's register port
`timescale 1ns/100ps
module pwd_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_write,
    output logic            reg_read,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end
    // Released data is inverted so a stale value is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        // Taken just before the edge: a clear-on-read would race a sample at it
        #4 d = reg_rdata;
        @(posedge clk);
        @(negedge clk);
        reg_read = 1'b0;
    endtask
    // Count refresh writes n as given, zero included; callers here pass nonzero values
    task automatic kick(input logic [7:0] n);
        wr(8'h1E, n);
    endtask
endmodule

/* File: tb/test_pwd_watchdog_regs.sv */
// Testbench: self-checking scenarios for the watchdog and configuration block
`timescale 1ns/100ps
module test_pwd_watchdog_regs;
    localparam logic [7:0] ID_VALUE = {5'h0A, 3'h1};  // Arbitrary part and revision codes
    logic clk, reset_n, oscillator_failure_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sw_mode_write_data, port_mode;
    logic reg_write, reg_read, interrupt_clear_strobe, hw_flag_irq, hw_controlled;
    logic [3:0] sw_mode_write, sw_power_on_req, class_request, class_done, class_high_found;
    logic [3:0] detection_skipped, power_on_grant, port_soft_reset, class_cycle_start, class_hold_mid_level;
    logic large_cap_detect_enable, detect_bypass_allow, oscillator_failure_flag_effective;
    logic [2:0] ac_disconnect_threshold;
    logic [11:0] current_limit_select;
    logic [3:0] current_limit_load;
    logic [1:0] current_limit_scale;
    logic [6:0] current_limit_percent;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    pwd_host_model host_u (.*);
    pwd_watchdog_regs #(.WD_TICK_CYCLES(10), .CLASS_GAP_CYCLES(8)) dut_u (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] a [6] = '{8'h1C, 8'h1E, 8'h1F, 8'h23, 8'h24, 8'h29};
        logic [7:0] e [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            host_u.rd(a[i], d);
            chk(d, e[i], "reset value");
        end
        host_u.wr(8'h1B, 8'h00);
        host_u.rd(8'h1B, d);
        chk(d, ID_VALUE, "identification");
        host_u.rd(8'h20, d);
        chk(d, 8'h00, "unmapped read");
        $display("t_regs done");
    endtask
    task automatic t_config();
        host_u.wr(8'h23, 8'h3F);
        chk(large_cap_detect_enable, 8'h01, "large cap");
        chk(detect_bypass_allow, 8'h01, "bypass");
        chk(ac_disconnect_threshold, 8'h07, "ac threshold");
        chk(oscillator_failure_flag_effective, 8'h00, "osc ignored");
        host_u.wr(8'h23, 8'h04);
        chk({large_cap_detect_enable, detect_bypass_allow, oscillator_failure_flag_effective}, 8'h01, "detect cfg");
        for (int s = 0; s < 4; s++) begin
            host_u.wr(8'h29, 8'(s));
            chk(current_limit_percent, 8'(100 - 5 * s), "scale percent");
        end
        host_u.wr(8'h24, 8'h50);
        @(negedge clk) class_high_found = 4'h2;
        @(negedge clk) class_high_found = 4'h0;
        chk(current_limit_select[5:3], 8'h05, "high power default");
        chk(current_limit_load, 8'h02, "limit load");
        $display("t_config done");
    endtask
    task automatic t_pb();
        host_u.wr(8'h1A, 8'h8F);
        chk({interrupt_clear_strobe, 3'h0, port_soft_reset}, 8'h8F, "strobes");
        @(negedge clk);
        chk({interrupt_clear_strobe, 3'h0, port_soft_reset}, 8'h00, "strobes clear");
        $display("t_pb done");
    endtask
    // The bench plays the analog side: each started cycle finishes three cycles later
    task automatic t_class(input logic [1:0] m, input int n);
        int starts = 0;
        int k = 99;
        @(negedge clk);
        sw_mode_write_data = {6'h00, m};
        sw_mode_write = 4'h1;
        @(negedge clk) sw_mode_write = 4'h0;
        class_request = 4'h1;
        @(negedge clk) class_request = 4'h0;
        repeat (80) begin
            class_done = 4'h0;
            if (class_cycle_start[0]) begin
                starts++;
                k = 0;
            end
            k++;
            if (k == 3) class_done = 4'h1;
            if (k == 7) chk(class_hold_mid_level, (starts < n) ? 8'h01 : 8'h00, "mid level hold");
            @(negedge clk);
        end
        chk(8'(starts), 8'(n), "class starts");
        $display("t_class done");
    endtask
    task automatic t_chip_reset();
        logic [7:0] d;
        host_u.wr(8'h29, 8'h03);
        host_u.wr(8'h1F, 8'h4F);
        host_u.wr(8'h1A, 8'h10);
        repeat (3) @(negedge clk);
        host_u.rd(8'h29, d);
        chk(d, 8'h00, "scale after soft reset");
        host_u.rd(8'h1C, d);
        chk(d, 8'h00, "enables after soft reset");
        $display("t_chip_reset done");
    endtask
    task automatic t_watchdog();
        logic [7:0] d;
        int i = 0;
        @(negedge clk);
        sw_mode_write_data = 8'h55;
        sw_mode_write = 4'hF;
        @(negedge clk) sw_mode_write = 4'h0;
        host_u.wr(8'h1F, 8'hC5);
        host_u.kick(8'h03);
        repeat (15) @(negedge clk);
        host_u.kick(8'h03);
        chk(hw_controlled, 8'h00, "no expiry after refresh");
        while (!hw_controlled && i < 60) begin
            @(negedge clk);
            i++;
        end
        chk(8'(i >= 18 && i <= 32), 8'h01, "expiry time");
        @(negedge clk);
        chk(port_mode, 8'h33, "expiry modes");
        chk(hw_flag_irq, 8'h01, "flag interrupt");
        sw_mode_write_data = 8'hFF;
        sw_mode_write = 4'hF;
        sw_power_on_req = 4'hF;
        #1 chk(power_on_grant, 8'h00, "power-on refused");
        @(negedge clk);
        sw_mode_write = 4'h0;
        sw_power_on_req = 4'h0;
        chk(port_mode, 8'h33, "mode locked");
        repeat (25) @(negedge clk);
        host_u.rd(8'h1E, d);
        chk(d, 8'h00, "count held at zero");
        host_u.rd(8'h1C, d);
        chk(d, 8'h0F, "hardware flags");
        host_u.rd(8'h1C, d);
        chk(d, 8'h00, "flags cleared on read");
        chk(hw_flag_irq, 8'h00, "interrupt gone");
        $display("t_watchdog done");
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Ceiling sits well above the roughly 400 cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        reset_n = 1'b0;
        {sw_mode_write_data, sw_mode_write, sw_power_on_req} = '0;
        {class_request, class_done, class_high_found, detection_skipped} = '0;
        oscillator_failure_flag = 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        t_regs();
        t_config();
        t_pb();
        host_u.wr(8'h1C, 8'h10);
        t_class(2'h3, 3);
        t_class(2'h2, 3);
        t_class(2'h1, 1);
        t_chip_reset();
        t_watchdog();
        end_of_test();
    end
endmodule
bind pwd_watchdog_regs pwd_checker chk_u (.*);
